// [logic/dbs_pkg.sv]
// Shared constants and types for the dual buck protection supervisor
package dbs_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Times in their own units
  // ----------------------------------------------------------------
  localparam int unsigned PG_ARM_NS    = 2_000_000;  // Power good and UV arm delay, 2 ms
  localparam int unsigned PG_QUAL_NS   = 510_000;    // Power good rise qualification, 510 us
  localparam int unsigned PG_DROP_NS   = 2_000;      // Power good drop delay, 2 us
  localparam int unsigned UV_DELAY_NS  = 32_000;     // Undervoltage delay counter, 32 us
  localparam int unsigned SS_NS        = 1_600_000;  // Shared soft start ramp, 1.6 ms
  localparam int unsigned SS_JOIN_NS   = 60_000;     // Simultaneous enable window, 60 us
  localparam int unsigned DEAD_NS      = 20;         // Gate dead time
  localparam int unsigned PUMP_HZ      = 270_000;    // Charge pump clock

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned PG_ARM_CYC   = PG_ARM_NS / CLK_PERIOD_NS;
  localparam int unsigned PG_QUAL_CYC  = PG_QUAL_NS / CLK_PERIOD_NS;
  localparam int unsigned PG_DROP_CYC  = PG_DROP_NS / CLK_PERIOD_NS;
  localparam int unsigned UV_DELAY_CYC = UV_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned SS_CYC       = SS_NS / CLK_PERIOD_NS;
  localparam int unsigned SS_JOIN_CYC  = SS_JOIN_NS / CLK_PERIOD_NS;
  localparam int unsigned DEAD_CYC     = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PUMP_HALF_CYC = CLK_HZ / (2 * PUMP_HZ);

  localparam int unsigned CNT_W  = 18;
  localparam int unsigned DEAD_W = 4;
  localparam int unsigned PUMP_W = 8;
  localparam int unsigned SYNC_STAGES_W = 22;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Comparator and pin flags of one channel
  typedef struct packed {
    logic enable_trip;      // channel_enable_trip above enable threshold
    logic fb_over;          // Feedback above overvoltage fraction
    logic fb_under;         // Feedback below undervoltage fraction
    logic in_tight;         // Output inside the tight window
    logic out_wide;         // Output outside the wide window
    logic vo_abs_over;      // Output sense above absolute limit
    logic vo_switch_ok;     // Output sense above switch-over threshold
    logic valley_over;      // Inductor current above trip level
    logic on_request;       // Modulator asks for an on phase
  } dbs_ch_cmp_t;

  typedef struct packed {
    logic top_gate_drive;
    logic bottom_gate_drive;
    logic discharge;
  } dbs_gate_t;

  typedef struct packed {
    logic overvoltage_latch;
    logic undervoltage_latch;
    logic power_good;
  } dbs_status_t;

  typedef enum logic [3:0] {
    CH_OFF  = 4'h1,
    CH_WAIT = 4'h2,
    CH_RAMP = 4'h4,
    CH_RUN  = 4'h8
  } dbs_ch_state_t;

endpackage

// [logic/dbs_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module dbs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// [logic/dbs_gate_seq.sv]
// Gate driver sequencer with dead time between top and bottom switch
`timescale 1ns/1ps
module dbs_gate_seq (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic want_top_i,
  input  wire logic want_bottom_i,
  output logic      top_o,
  output logic      bottom_o
);

  logic [dbs_pkg::DEAD_W-1:0] dead_r;

  // ----------------------------------------------------------------
  // Switch sequencing
  // ----------------------------------------------------------------
  // Any switch turning off reloads the dead time; nothing turns on until it expires
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      top_o    <= 1'b0;
      bottom_o <= 1'b0;
      dead_r   <= '0;
    end else if (top_o && !want_top_i) begin
      top_o  <= 1'b0;
      dead_r <= dbs_pkg::DEAD_W'(dbs_pkg::DEAD_CYC);
    end else if (bottom_o && !want_bottom_i) begin
      bottom_o <= 1'b0;
      dead_r   <= dbs_pkg::DEAD_W'(dbs_pkg::DEAD_CYC);
    end else if (dead_r != '0) begin
      dead_r <= dead_r - 1'b1;
    end else if (want_top_i && !bottom_o) begin
      top_o <= 1'b1;
    end else if (want_bottom_i && !want_top_i && !top_o) begin
      bottom_o <= 1'b1;
    end
  end

endmodule

// [logic/dbs_supervisor.sv]
// Supervisor for a two-channel step-down controller: power good, protection, sequencing
//
// Function
// - Ch1 good and high: 5V rail switches over
// - Ch2 good and high: 3.3V rail switches over
// - Combined power good is AND of channels
// - Power good armed 2 ms after enable
// - Good rises after 510 us inside window
// - Good drops 2 us after leaving window
// - Power good pin only pulls low
// - Channel disabled: discharge transistor on
// - Dead time between top and bottom switching
// - Pump clock runs only with master enable
// - Hold off phase while valley current high
// - Overvoltage latches top off, bottom on
// - Absolute output overvoltage turns top off
// - Undervoltage persisting 32 us latches both channels
// - Undervoltage check armed 2 ms after enable
// - Low 5V standby rail stops both channels
// - Low 3.3V standby rail stops both channels
// - Overtemperature stops channels and regulators, self-restarts
// - Enable starts shared soft start ramp
// - Shared ramp: wait, or join within 60 us
`timescale 1ns/1ps
module dbs_supervisor #(
  parameter int unsigned PG_ARM_CYC  = dbs_pkg::PG_ARM_CYC,
  parameter int unsigned PG_QUAL_CYC = dbs_pkg::PG_QUAL_CYC,
  parameter int unsigned SS_CYC      = dbs_pkg::SS_CYC,
  parameter int unsigned SS_JOIN_CYC = dbs_pkg::SS_JOIN_CYC
) (
  input  wire logic                clock_i,
  input  wire logic                resetn_i,
  input  wire logic                master_enable_pin_i,
  input  wire logic                standby_rail_5v_low_i,
  input  wire logic                standby_rail_3v3_low_i,
  input  wire logic                over_temp_i,
  input  wire dbs_pkg::dbs_ch_cmp_t ch1_cmp_i,
  input  wire dbs_pkg::dbs_ch_cmp_t ch2_cmp_i,
  input  wire logic                combined_power_good_i,
  output logic                     combined_power_good_o,
  output logic                     combined_power_good_oe_n_o,
  output dbs_pkg::dbs_gate_t       ch1_gate_o,
  output dbs_pkg::dbs_gate_t       ch2_gate_o,
  output dbs_pkg::dbs_status_t     ch1_status_o,
  output dbs_pkg::dbs_status_t     ch2_status_o,
  output logic                     ldo_5v_enable_o,
  output logic                     rail_5v_switch_o,
  output logic                     ldo_3v3_enable_o,
  output logic                     rail_3v3_switch_o,
  output logic                     pump_clock_out_o,
  output logic                     pg_pin_low_seen_o
);

  localparam int unsigned CW = dbs_pkg::CNT_W;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when a counter has reached its last cycle of a wait
  function automatic logic at_limit(input logic [CW-1:0] cnt, input int unsigned lim);
    logic [CW-1:0] last;
    last = CW'(lim - 1);
    return cnt >= last;
  endfunction

  // Saturating increment
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] cnt);
    logic [CW-1:0] res;
    res = (cnt == '1) ? cnt : cnt + 1'b1;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [dbs_pkg::SYNC_STAGES_W-1:0] raw_w;
  logic [dbs_pkg::SYNC_STAGES_W-1:0] syn_w;
  dbs_pkg::dbs_ch_cmp_t              cmp_s [2];
  logic                              master_s;
  logic                              rail5_low_s;
  logic                              rail3_low_s;
  logic                              hot_s;
  logic                              pg_pin_s;

  assign raw_w = {ch2_cmp_i, ch1_cmp_i, master_enable_pin_i, standby_rail_5v_low_i,
                  standby_rail_3v3_low_i, over_temp_i};

  dbs_sync #(
    .W (dbs_pkg::SYNC_STAGES_W)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .async_i  (raw_w),
    .sync_o   (syn_w)
  );

  assign cmp_s[1]    = syn_w[21:13];
  assign cmp_s[0]    = syn_w[12:4];
  assign master_s    = syn_w[3];
  assign rail5_low_s = syn_w[2];
  assign rail3_low_s = syn_w[1];
  assign hot_s       = syn_w[0];

  // Pin readback of the shared power good line
  logic pg_meta_r;
  logic pg_pin_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pg_meta_r <= 1'b0;
      pg_pin_r  <= 1'b0;
    end else begin
      pg_meta_r <= combined_power_good_i;
      pg_pin_r  <= pg_meta_r;
    end
  end

  assign pg_pin_s = pg_pin_r;

  // ----------------------------------------------------------------
  // Global shutdown
  // ----------------------------------------------------------------
  logic shut_all;

  assign shut_all = !master_s || rail5_low_s || rail3_low_s || hot_s;

  // ----------------------------------------------------------------
  // Enable age counters
  // ----------------------------------------------------------------
  logic [CW-1:0] arm_cnt_r [2];
  logic          armed     [2];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < 2; c++) begin
        arm_cnt_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!cmp_s[c].enable_trip || !master_s) begin
          arm_cnt_r[c] <= '0;
        end else if (!at_limit(arm_cnt_r[c], PG_ARM_CYC)) begin
          arm_cnt_r[c] <= sat_inc(arm_cnt_r[c]);
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      armed[c] = at_limit(arm_cnt_r[c], PG_ARM_CYC);
    end
  end

  // ----------------------------------------------------------------
  // Soft start sequencing
  // ----------------------------------------------------------------
  dbs_pkg::dbs_ch_state_t st_r [2];
  logic [CW-1:0]          ss_cnt_r;
  logic                   ramp_busy;
  logic                   join_ok;
  logic                   start_now [2];
  logic                   ch_down   [2];
  logic                   ov_r      [2];
  logic                   uv_r      [2];

  assign ramp_busy = (st_r[0] == dbs_pkg::CH_RAMP) || (st_r[1] == dbs_pkg::CH_RAMP);
  assign join_ok   = !at_limit(ss_cnt_r, SS_JOIN_CYC);

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ch_down[c]   = !cmp_s[c].enable_trip || shut_all;
      start_now[c] = (st_r[c] == dbs_pkg::CH_WAIT) && (!ramp_busy || join_ok);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r[0] <= dbs_pkg::CH_OFF;
      st_r[1] <= dbs_pkg::CH_OFF;
    end else begin
      for (int c = 0; c < 2; c++) begin
        unique case (st_r[c])
          dbs_pkg::CH_OFF: begin
            if (!ch_down[c]) begin
              st_r[c] <= dbs_pkg::CH_WAIT;
            end
          end
          dbs_pkg::CH_WAIT: begin
            if (ch_down[c]) begin
              st_r[c] <= dbs_pkg::CH_OFF;
            end else if (start_now[c]) begin
              st_r[c] <= dbs_pkg::CH_RAMP;
            end
          end
          dbs_pkg::CH_RAMP: begin
            if (ch_down[c]) begin
              st_r[c] <= dbs_pkg::CH_OFF;
            end else if (at_limit(ss_cnt_r, SS_CYC)) begin
              st_r[c] <= dbs_pkg::CH_RUN;
            end
          end
          dbs_pkg::CH_RUN: begin
            if (ch_down[c]) begin
              st_r[c] <= dbs_pkg::CH_OFF;
            end
          end
          default: begin
            st_r[c] <= dbs_pkg::CH_OFF;
          end
        endcase
      end
    end
  end

  // Joining channel restarts the shared ramp so both finish together
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ss_cnt_r <= '0;
    end else if (start_now[0] || start_now[1]) begin
      ss_cnt_r <= '0;
    end else if (ramp_busy) begin
      ss_cnt_r <= sat_inc(ss_cnt_r);
    end else begin
      ss_cnt_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Power good per channel
  // ----------------------------------------------------------------
  logic [CW-1:0] qual_cnt_r [2];
  logic [CW-1:0] drop_cnt_r [2];
  logic          pg_r       [2];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < 2; c++) begin
        qual_cnt_r[c] <= '0;
        drop_cnt_r[c] <= '0;
        pg_r[c]       <= 1'b0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!armed[c]) begin
          qual_cnt_r[c] <= '0;
          drop_cnt_r[c] <= '0;
          pg_r[c]       <= 1'b0;
        end else if (!pg_r[c]) begin
          drop_cnt_r[c] <= '0;
          if (!cmp_s[c].in_tight) begin
            qual_cnt_r[c] <= '0;
          end else if (at_limit(qual_cnt_r[c], PG_QUAL_CYC)) begin
            pg_r[c] <= 1'b1;
          end else begin
            qual_cnt_r[c] <= sat_inc(qual_cnt_r[c]);
          end
        end else begin
          qual_cnt_r[c] <= '0;
          if (!cmp_s[c].out_wide) begin
            drop_cnt_r[c] <= '0;
          end else if (at_limit(drop_cnt_r[c], dbs_pkg::PG_DROP_CYC)) begin
            pg_r[c] <= 1'b0;
          end else begin
            drop_cnt_r[c] <= sat_inc(drop_cnt_r[c]);
          end
        end
      end
    end
  end

  // Open drain: output level stays low, enable low pulls the pin down
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      combined_power_good_o      <= 1'b0;
      combined_power_good_oe_n_o <= 1'b0;
      pg_pin_low_seen_o          <= 1'b0;
    end else begin
      combined_power_good_o      <= 1'b0;
      combined_power_good_oe_n_o <= pg_r[0] && pg_r[1];
      pg_pin_low_seen_o          <= !pg_pin_s;
    end
  end

  // ----------------------------------------------------------------
  // Overvoltage and undervoltage latches
  // ----------------------------------------------------------------
  logic [CW-1:0] uv_cnt_r [2];
  logic          uv_any;

  assign uv_any = uv_r[0] || uv_r[1];

  // Setting wins over clearing in the same cycle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < 2; c++) begin
        ov_r[c]     <= 1'b0;
        uv_r[c]     <= 1'b0;
        uv_cnt_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cmp_s[c].enable_trip && master_s && cmp_s[c].fb_over) begin
          ov_r[c] <= 1'b1;
        end else if (!cmp_s[c].enable_trip || !master_s) begin
          ov_r[c] <= 1'b0;
        end
        if (!armed[c] || !cmp_s[c].fb_under) begin
          uv_cnt_r[c] <= '0;
        end else begin
          uv_cnt_r[c] <= sat_inc(uv_cnt_r[c]);
        end
        if (armed[c] && cmp_s[c].fb_under
            && at_limit(uv_cnt_r[c], dbs_pkg::UV_DELAY_CYC)) begin
          uv_r[c] <= 1'b1;
        end else if (!cmp_s[c].enable_trip || !master_s) begin
          uv_r[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Gate requests
  // ----------------------------------------------------------------
  logic want_top [2];
  logic want_bot [2];
  logic top_w    [2];
  logic bot_w    [2];
  logic active   [2];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      active[c] = (st_r[c] == dbs_pkg::CH_RAMP) || (st_r[c] == dbs_pkg::CH_RUN);
      if (shut_all || uv_any || !active[c]) begin
        want_top[c] = 1'b0;
        want_bot[c] = 1'b0;
      end else if (ov_r[c]) begin
        want_top[c] = 1'b0;
        want_bot[c] = 1'b1;
      end else begin
        want_top[c] = cmp_s[c].on_request && !cmp_s[c].vo_abs_over
                      && (top_w[c] || !cmp_s[c].valley_over);
        want_bot[c] = !want_top[c];
      end
    end
  end

  dbs_gate_seq u_seq1 (
    .clock_i       (clock_i),
    .resetn_i      (resetn_i),
    .want_top_i    (want_top[0]),
    .want_bottom_i (want_bot[0]),
    .top_o         (top_w[0]),
    .bottom_o      (bot_w[0])
  );

  dbs_gate_seq u_seq2 (
    .clock_i       (clock_i),
    .resetn_i      (resetn_i),
    .want_top_i    (want_top[1]),
    .want_bottom_i (want_bot[1]),
    .top_o         (top_w[1]),
    .bottom_o      (bot_w[1])
  );

  // ----------------------------------------------------------------
  // Discharge and status
  // ----------------------------------------------------------------
  logic dis_r [2];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dis_r[0]     <= 1'b1;
      dis_r[1]     <= 1'b1;
      ch1_status_o <= '0;
      ch2_status_o <= '0;
    end else begin
      dis_r[0]     <= !cmp_s[0].enable_trip;
      dis_r[1]     <= !cmp_s[1].enable_trip;
      ch1_status_o <= '{overvoltage_latch: ov_r[0], undervoltage_latch: uv_r[0],
                        power_good: pg_r[0]};
      ch2_status_o <= '{overvoltage_latch: ov_r[1], undervoltage_latch: uv_r[1],
                        power_good: pg_r[1]};
    end
  end

  assign ch1_gate_o = '{top_gate_drive: top_w[0], bottom_gate_drive: bot_w[0],
                        discharge: dis_r[0]};
  assign ch2_gate_o = '{top_gate_drive: top_w[1], bottom_gate_drive: bot_w[1],
                        discharge: dis_r[1]};

  // ----------------------------------------------------------------
  // Standby rail switch-over
  // ----------------------------------------------------------------
  // Regulators stay on while master is up unless hot or switched over
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rail_5v_switch_o  <= 1'b0;
      rail_3v3_switch_o <= 1'b0;
      ldo_5v_enable_o   <= 1'b0;
      ldo_3v3_enable_o  <= 1'b0;
    end else begin
      rail_5v_switch_o  <= !hot_s && pg_r[0] && cmp_s[0].vo_switch_ok;
      rail_3v3_switch_o <= !hot_s && pg_r[1] && cmp_s[1].vo_switch_ok;
      ldo_5v_enable_o   <= master_s && !hot_s
                           && !(pg_r[0] && cmp_s[0].vo_switch_ok);
      ldo_3v3_enable_o  <= master_s && !hot_s
                           && !(pg_r[1] && cmp_s[1].vo_switch_ok);
    end
  end

  // ----------------------------------------------------------------
  // Charge pump clock
  // ----------------------------------------------------------------
  logic [dbs_pkg::PUMP_W-1:0] pump_cnt_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pump_cnt_r       <= '0;
      pump_clock_out_o <= 1'b0;
    end else if (!master_s) begin
      pump_cnt_r       <= '0;
      pump_clock_out_o <= 1'b0;
    end else if (pump_cnt_r == dbs_pkg::PUMP_W'(dbs_pkg::PUMP_HALF_CYC - 1)) begin
      pump_cnt_r       <= '0;
      pump_clock_out_o <= !pump_clock_out_o;
    end else begin
      pump_cnt_r <= pump_cnt_r + 1'b1;
    end
  end

endmodule

// [testbench/dbs_pin_model.sv]
// Pull-up resistor on the open-drain power good pin
`timescale 1ns/1ps
module dbs_pin_model (
  input  wire logic oe_n_i,
  input  wire logic data_i,
  output logic      pin_o
);
  // Released pin is lifted by the outside pull-up
  assign pin_o = oe_n_i ? 1'b1 : data_i;
endmodule

// [testbench/dbs_chk.sv]
// Port checker for the supervisor
`timescale 1ns/1ps
module dbs_chk (
  input wire logic                 clock_i,
  input wire logic                 resetn_i,
  input wire logic                 master_enable_pin_i,
  input wire logic                 over_temp_i,
  input wire dbs_pkg::dbs_ch_cmp_t ch1_cmp_i,
  input wire logic                 combined_power_good_o,
  input wire logic                 combined_power_good_oe_n_o,
  input wire dbs_pkg::dbs_gate_t   ch1_gate_o,
  input wire dbs_pkg::dbs_gate_t   ch2_gate_o,
  input wire dbs_pkg::dbs_status_t ch1_status_o,
  input wire dbs_pkg::dbs_status_t ch2_status_o,
  input wire logic                 ldo_3v3_enable_o,
  input wire logic                 pump_clock_out_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  pg_drain_a: assert property (!combined_power_good_o)
    else $error("pg data high");
  pg_and_a: assert property (combined_power_good_oe_n_o |->
    ch1_status_o.power_good && ch2_status_o.power_good) else $error("pg not AND");
  dead_tb_a: assert property ($fell(ch1_gate_o.top_gate_drive) |->
    !ch1_gate_o.bottom_gate_drive [*3]) else $error("no dead time top");
  dead_bt_a: assert property ($fell(ch1_gate_o.bottom_gate_drive) |->
    !ch1_gate_o.top_gate_drive [*3]) else $error("no dead time bottom");
  discharge_on_a: assert property (!ch1_cmp_i.enable_trip [*5] |->
    ch1_gate_o.discharge && !ch1_gate_o.top_gate_drive) else $error("no discharge");
  pump_off_a: assert property (!master_enable_pin_i [*4] |-> !pump_clock_out_o)
    else $error("pump runs");
  ov_top_a: assert property (ch2_status_o.overvoltage_latch [*2] |->
    !ch2_gate_o.top_gate_drive) else $error("top on in ov");
  valley_hold_a: assert property ($rose(ch1_gate_o.top_gate_drive) |->
    !$past(ch1_cmp_i.valley_over, 3)) else $error("top on at high valley");
  abs_ov_a: assert property (ch1_cmp_i.vo_abs_over [*4] |->
    !ch1_gate_o.top_gate_drive) else $error("top on above limit");
  uv_both_a: assert property (ch1_status_o.undervoltage_latch [*2] |->
    !ch2_gate_o.top_gate_drive && !ch2_gate_o.bottom_gate_drive) else $error("ch2 on in uv");
  hot_off_a: assert property (over_temp_i [*4] |->
    !ldo_3v3_enable_o && !ch1_gate_o.top_gate_drive) else $error("on while hot");
  cover property ($rose(combined_power_good_oe_n_o));
  cover property ($rose(ch1_status_o.undervoltage_latch));
  cover property ($rose(ch2_status_o.overvoltage_latch));
endmodule
bind dbs_supervisor dbs_chk dbs_chk_inst (.clock_i, .resetn_i, .master_enable_pin_i,
  .over_temp_i, .ch1_cmp_i, .combined_power_good_o, .combined_power_good_oe_n_o,
  .ch1_gate_o, .ch2_gate_o, .ch1_status_o, .ch2_status_o, .ldo_3v3_enable_o,
  .pump_clock_out_o);

// [testbench/tb_top.sv]
// Self-checking bench of the supervisor
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0, resetn_i = 1'b0, mst = 1'b1, uv5 = 1'b0, uv3 = 1'b0, hot = 1'b0;
  logic rnd = 1'b0, pg_o, oe_n, ldo5, sw5, ldo3, sw3, pump, seen, pin;
  dbs_pkg::dbs_gate_t   g1, g2;
  dbs_pkg::dbs_status_t s1, s2;
  dbs_pkg::dbs_ch_cmp_t c1 = '0, c2 = '0;
  int err_total = 0, n_tests = 0, n, k, seed = 32'h8FAF;
  always #5 clock_i = ~clock_i;
  dbs_supervisor #(.PG_ARM_CYC(50), .PG_QUAL_CYC(20), .SS_CYC(40), .SS_JOIN_CYC(8))
  dbs_supervisor_inst (.clock_i, .resetn_i, .master_enable_pin_i(mst),
    .standby_rail_5v_low_i(uv5), .standby_rail_3v3_low_i(uv3), .over_temp_i(hot),
    .ch1_cmp_i(c1), .ch2_cmp_i(c2), .combined_power_good_i(pin),
    .combined_power_good_o(pg_o), .combined_power_good_oe_n_o(oe_n), .ch1_gate_o(g1),
    .ch2_gate_o(g2), .ch1_status_o(s1), .ch2_status_o(s2), .ldo_5v_enable_o(ldo5),
    .rail_5v_switch_o(sw5), .ldo_3v3_enable_o(ldo3), .rail_3v3_switch_o(sw3),
    .pump_clock_out_o(pump), .pg_pin_low_seen_o(seen));
  dbs_pin_model dbs_pin_model_inst (.oe_n_i(oe_n), .data_i(pg_o), .pin_o(pin));
  always @(negedge clock_i) begin
    if (rnd) begin
      {c1.on_request, c1.valley_over, c2.on_request} <= 3'($random(seed));
    end
  end
  function automatic logic in_rng(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: pick = oe_n;
      1: pick = pump;
      default: pick = s1.undervoltage_latch;
    endcase
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      $display("Error %s expected %0h seen %0h", s, e, v);
      err_total++;
    end
  endtask
  task automatic tick(input int t);
    repeat (t) @(negedge clock_i);
  endtask
  task automatic wt(input int s, input logic v, input int l);
    n = 0;
    while (pick(s) !== v && n < l) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= l) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    test_done();
  end
  initial begin
    tick(8);
    resetn_i = 1'b1;
    rnd = 1'b1;
    c1 = '{enable_trip: 1'b1, in_tight: 1'b1, vo_switch_ok: 1'b1, default: 1'b0};
    c2 = '{enable_trip: 1'b1, in_tight: 1'b1, default: 1'b0};
    wt(0, 1'b1, 200);
    chk("pg_rise", 1, in_rng(n, 70, 82));
    chk("pin", 1, pin);
    chk("sw5", 2'h1, {ldo5, sw5});
    chk("sw3", 2'h2, {ldo3, sw3});
    c2.vo_switch_ok = 1'b1;
    tick(6);
    chk("sw3_on", 2'h1, {ldo3, sw3});
    chk("pg_seen", 0, seen);
    wt(1, 1'b1, 400);
    wt(1, 1'b0, 400);
    chk("pump_half", dbs_pkg::PUMP_HALF_CYC, n);
    c1.vo_abs_over = 1'b1;
    tick(6);
    chk("abs_top", 0, g1.top_gate_drive);
    c1.vo_abs_over = 1'b0;
    $display("startup done");
    c1.in_tight = 1'b0;
    c1.out_wide = 1'b1;
    wt(0, 1'b0, 300);
    chk("pg_drop", 1, in_rng(n, 200, 208));
    c2.fb_over = 1'b1;
    tick(10);
    chk("ov2", 3'h5, {s2.overvoltage_latch, g2.top_gate_drive, g2.bottom_gate_drive});
    chk("pg_low_seen", 1, seen);
    c2.fb_over = 1'b0;
    tick(5);
    chk("ov2_hold", 1, s2.overvoltage_latch);
    c2.enable_trip = 1'b0;
    tick(5);
    chk("ov2_clr", 2'h1, {s2.overvoltage_latch, g2.discharge});
    $display("ov done");
    for (k = 0; k < 3; k++) begin
      {hot, uv3, uv5} = 3'h1 << k;
      tick(5);
      chk("shut", 2'h0, {g1.top_gate_drive, g1.bottom_gate_drive});
      if (k == 2) chk("hot_ldo", 2'h0, {ldo3, sw5});
      {hot, uv3, uv5} = 3'h0;
      tick(5);
    end
    chk("ldo_back", 1, ldo3);
    c1 = '0;
    tick(5);
    c1 = '{enable_trip: 1'b1, fb_under: 1'b1, default: 1'b0};
    c2.enable_trip = 1'b1;
    wt(2, 1'b1, 3400);
    chk("uv_time", 1, in_rng(n, 3250, 3262));
    tick(2);
    chk("uv_other", 2'h0, {g2.top_gate_drive, g2.bottom_gate_drive});
    mst = 1'b0;
    tick(5);
    chk("mst_off", 2'h0, {pump, s1.undervoltage_latch});
    $display("uv done");
    test_done();
  end
endmodule
